//--- rsq_defines.svh
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

`define RSQ_CAUSE_ADDR 16'hFE01
`define RSQ_SVC_ADDR 16'hFFFF
`define RSQ_VEC_NORMAL 16'hFFFE
`define RSQ_VEC_MONITOR 16'hFEFE

`define RSQ_BIT_PWR 7
`define RSQ_BIT_PIN 6
`define RSQ_BIT_WDOG 5
`define RSQ_BIT_OPC 4
`define RSQ_BIT_FETCH 3
`define RSQ_BIT_UV 1
`define RSQ_CAUSE_RST 8'h80

`define RSQ_DRIVE_CYC 32
`define RSQ_RELEASE_CYC 64
`define RSQ_LONG_CYC 4096
`define RSQ_SHORT_WAKE_CYC 32
`define RSQ_PIN_SHORT_CYC 67
`define RSQ_PIN_LONG_CYC 4163

`endif

//--- rsq_pkg.sv
package rsq_pkg;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_LONG = 3'b001,
		ST_DRIVE = 3'b010,
		ST_HOLD = 3'b011,
		ST_EXT = 3'b100,
		ST_STOP = 3'b101,
		ST_WAKE = 3'b110,
		ST_WAIT = 3'b111
	} rsq_state_t;
	typedef logic [12:0] rsq_cnt_t;
endpackage

//--- rsq_cnt_if.sv
`timescale 1ns/1ps
interface rsq_cnt_if;
	logic clr;
	logic svc;
	rsq_pkg::rsq_cnt_t cnt;
	logic ovf;
	modport ctl (output clr, output svc, input cnt, input ovf);
	modport pre (input clr, input svc, output cnt, output ovf);
endinterface

//--- rsq_prescale.sv
`timescale 1ns/1ps
module rsq_prescale (
	input wire logic i_clk,
	input wire logic i_srst,
	rsq_cnt_if.pre bus
);
	rsq_pkg::rsq_cnt_t cnt_r;
	logic ovf_r;

	assign bus.cnt = cnt_r;
	assign bus.ovf = ovf_r;

	always_ff @(posedge i_clk) begin
		if (i_srst || bus.clr) begin
			cnt_r <= 13'h0000;
		end else if (bus.svc) begin
			cnt_r <= {9'h000, cnt_r[3:0]};
		end else begin
			cnt_r <= cnt_r + 13'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ovf_r <= 1'b0;
		end else begin
			ovf_r <= (cnt_r == 13'h1FFF) && !bus.clr && !bus.svc;
		end
	end
endmodule

//--- rsq_sequencer.sv
`timescale 1ns/1ps
`include "rsq_defines.svh"
module rsq_sequencer #(
	parameter int P_PIN_LONG_CYC = `RSQ_PIN_LONG_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_rst_pin_in,
	output logic o_rst_pin_out,
	output logic o_rst_pin_oe,
	input wire logic i_powerup_pulse,
	input wire logic i_undervolt,
	input wire logic i_watchdog_ovf,
	input wire logic i_bad_opcode,
	input wire logic i_opcode_fetch,
	input wire logic i_fetch_unmapped,
	input wire logic i_stop_exec,
	input wire logic i_wait_exec,
	input wire logic i_wake,
	input wire logic i_halt_allow,
	input wire logic i_short_wake_select,
	input wire logic i_monitor_mode,
	output logic o_internal_reset,
	output logic [15:0] o_vector_addr,
	output logic o_cpu_clk_en,
	output logic o_module_clk_en,
	output logic o_core_src_clk_en,
	output logic o_bus_clk_phase,
	output logic o_wdog_tick,
	output logic o_wdog_clear
);
	rsq_cnt_if cif ();

	rsq_prescale u_pre (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.bus(cif.pre)
	);

	// async inputs: pin, watchdog, undervolt, power-up
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] sync3_r;
	logic pin_low;
	logic wdog_ev;
	logic uv_ev;
	logic pwr_ev;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sync1_r <= 4'hF;
			sync2_r <= 4'hF;
			sync3_r <= 4'hF;
		end else begin
			sync1_r <= {i_powerup_pulse, i_undervolt, i_watchdog_ovf, !i_rst_pin_in};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// pin level read only after synchroniser
	assign pin_low = sync2_r[0];
	assign wdog_ev = sync2_r[1] && !sync3_r[1];
	assign uv_ev = sync2_r[2] && !sync3_r[2];
	assign pwr_ev = sync2_r[3] && !sync3_r[3];

	rsq_pkg::rsq_state_t state_r;
	rsq_pkg::rsq_state_t state_nxt;
	logic long_src_r;
	logic long_src_nxt;
	logic [7:0] cause_r;
	logic [7:0] cause_nxt;
	logic [12:0] pin_cnt_r;
	logic [12:0] pin_thr;
	logic opc_ev;
	logic fetch_ev;
	logic int_ev;
	logic svc_wr;
	logic cnt_clr;
	logic [12:0] hold_end;
	logic [12:0] wake_end;

	// stop without halt permission is an illegal opcode
	assign opc_ev = i_bad_opcode || (i_stop_exec && !i_halt_allow);
	// data accesses to holes are ignored
	assign fetch_ev = i_opcode_fetch && i_fetch_unmapped;
	assign int_ev = pwr_ev || uv_ev || wdog_ev || opc_ev || fetch_ev;
	// any write to the top vector byte services the watchdog
	assign svc_wr = i_wr && (i_addr == `RSQ_SVC_ADDR);
	assign hold_end = long_src_r ? 13'(`RSQ_LONG_CYC + `RSQ_RELEASE_CYC - 1)
		: 13'(`RSQ_RELEASE_CYC - 1);
	// short wake option picks 32, else 4096
	assign wake_end = i_short_wake_select ? 13'(`RSQ_SHORT_WAKE_CYC - 1)
		: 13'(`RSQ_LONG_CYC - 1);
	// threshold grows after power-up or undervolt
	assign pin_thr = long_src_r ? 13'(P_PIN_LONG_CYC - 1) : 13'(`RSQ_PIN_SHORT_CYC - 1);

	always_comb begin
		state_nxt = state_r;
		long_src_nxt = long_src_r;
		cnt_clr = 1'b0;
		if (pwr_ev || uv_ev) begin
			// long pin drive for power-up and undervolt
			state_nxt = rsq_pkg::ST_LONG;
			long_src_nxt = 1'b1;
			cnt_clr = 1'b1;
		end else if (int_ev && state_r != rsq_pkg::ST_LONG) begin
			state_nxt = rsq_pkg::ST_DRIVE;
			long_src_nxt = 1'b0;
			cnt_clr = 1'b1;
		end else begin
			case (state_r)
				rsq_pkg::ST_RUN: begin
					if (pin_low) begin
						state_nxt = rsq_pkg::ST_EXT;
					end else if (i_stop_exec) begin
						state_nxt = rsq_pkg::ST_STOP;
						cnt_clr = 1'b1;
					end else if (i_wait_exec) begin
						state_nxt = rsq_pkg::ST_WAIT;
					end
				end
				rsq_pkg::ST_LONG: begin
					if (cif.cnt == 13'(`RSQ_LONG_CYC - 1)) begin
						state_nxt = rsq_pkg::ST_HOLD;
					end
				end
				rsq_pkg::ST_DRIVE: begin
					if (cif.cnt == 13'(`RSQ_DRIVE_CYC - 1)) begin
						state_nxt = rsq_pkg::ST_HOLD;
					end
				end
				rsq_pkg::ST_HOLD: begin
					if (cif.cnt == hold_end) begin
						state_nxt = rsq_pkg::ST_RUN;
					end
				end
				rsq_pkg::ST_EXT: begin
					if (!pin_low) begin
						state_nxt = rsq_pkg::ST_RUN;
					end
				end
				rsq_pkg::ST_STOP: begin
					cnt_clr = 1'b1;
					if (i_wake || pin_low) begin
						state_nxt = rsq_pkg::ST_WAKE;
					end
				end
				rsq_pkg::ST_WAKE: begin
					if (cif.cnt == wake_end) begin
						state_nxt = pin_low ? rsq_pkg::ST_EXT : rsq_pkg::ST_RUN;
					end
				end
				rsq_pkg::ST_WAIT: begin
					if (pin_low) begin
						state_nxt = rsq_pkg::ST_EXT;
					end else if (i_wake) begin
						state_nxt = rsq_pkg::ST_RUN;
					end
				end
				default: begin
					state_nxt = rsq_pkg::ST_RUN;
				end
			endcase
		end
	end

	assign cif.clr = cnt_clr;
	assign cif.svc = svc_wr && !cnt_clr;

	// reset behaves like power-up so the long sequence always runs first
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= rsq_pkg::ST_LONG;
			long_src_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			long_src_r <= long_src_nxt;
		end
	end

	// saturating low-time counter for the pin
	always_ff @(posedge i_clk) begin
		if (i_srst || !pin_low) begin
			pin_cnt_r <= 13'h0000;
		end else if (pin_cnt_r != 13'h1FFF) begin
			pin_cnt_r <= pin_cnt_r + 13'h0001;
		end
	end

	always_comb begin
		cause_nxt = cause_r;
		// cleared on read; a set in the same cycle wins
		if (i_rd && i_addr == `RSQ_CAUSE_ADDR) begin
			cause_nxt = 8'h00;
		end
		// each source sets its own flag; power-up replaces the whole byte with its flag alone
		if (pin_low && pin_cnt_r == pin_thr) begin
			// pin flag after the low time
			cause_nxt[`RSQ_BIT_PIN] = 1'b1;
		end
		if (wdog_ev) begin
			cause_nxt[`RSQ_BIT_WDOG] = 1'b1;
		end
		if (opc_ev) begin
			cause_nxt[`RSQ_BIT_OPC] = 1'b1;
		end
		if (fetch_ev) begin
			cause_nxt[`RSQ_BIT_FETCH] = 1'b1;
		end
		if (uv_ev) begin
			cause_nxt[`RSQ_BIT_UV] = 1'b1;
		end
		if (pwr_ev) begin
			cause_nxt = `RSQ_CAUSE_RST;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cause_r <= `RSQ_CAUSE_RST;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (i_rd && i_addr == `RSQ_CAUSE_ADDR) begin
			o_rdata <= cause_r;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// open-drain pin, only ever pulled low
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rst_pin_out <= 1'b0;
		end else begin
			o_rst_pin_out <= 1'b0;
		end
	end

	// pin driven in long and drive phases
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rst_pin_oe <= 1'b1;
		end else begin
			o_rst_pin_oe <= (state_nxt == rsq_pkg::ST_LONG) || (state_nxt == rsq_pkg::ST_DRIVE);
		end
	end

	// internal reset in every reset state
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_internal_reset <= 1'b1;
		end else begin
			o_internal_reset <= (state_nxt == rsq_pkg::ST_LONG) || (state_nxt == rsq_pkg::ST_DRIVE)
				|| (state_nxt == rsq_pkg::ST_HOLD) || (state_nxt == rsq_pkg::ST_EXT);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_vector_addr <= `RSQ_VEC_NORMAL;
		end else begin
			o_vector_addr <= i_monitor_mode ? `RSQ_VEC_MONITOR : `RSQ_VEC_NORMAL;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_cpu_clk_en <= 1'b0;
		end else begin
			o_cpu_clk_en <= (state_nxt == rsq_pkg::ST_RUN);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_module_clk_en <= 1'b0;
		end else begin
			o_module_clk_en <= (state_nxt == rsq_pkg::ST_RUN) || (state_nxt == rsq_pkg::ST_WAIT);
		end
	end

	// core source runs through reset, off only in stop
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_core_src_clk_en <= 1'b1;
		end else begin
			o_core_src_clk_en <= (state_nxt != rsq_pkg::ST_STOP);
		end
	end

	// bus clock phase toggles at half rate
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_bus_clk_phase <= 1'b0;
		end else begin
			o_bus_clk_phase <= !o_bus_clk_phase;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_wdog_tick <= 1'b0;
		end else begin
			o_wdog_tick <= cif.ovf;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_wdog_clear <= 1'b0;
		end else begin
			o_wdog_clear <= svc_wr;
		end
	end
endmodule

//--- rsq_sequencer_assertions.sv
`timescale 1ns/1ps
module rsq_seq_chk #(
	parameter int P_PIN_LONG_CYC = 4163
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rst_pin_in,
	input wire logic i_bad_opcode,
	input wire logic i_stop_exec,
	input wire logic i_halt_allow,
	input wire logic i_monitor_mode,
	input wire logic o_rst_pin_oe,
	input wire logic o_internal_reset,
	input wire logic [15:0] o_vector_addr,
	input wire logic o_cpu_clk_en,
	input wire logic o_module_clk_en,
	input wire logic o_bus_clk_phase,
	input wire logic o_wdog_clear
);
	// counts a whole drive run, since a repetition cannot reach the long figure
	logic [12:0] oe_len_r;
	always_ff @(posedge i_clk) begin
		if (i_srst || !o_rst_pin_oe) begin
			oe_len_r <= 13'h0000;
		end else begin
			oe_len_r <= oe_len_r + 13'h0001;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	phase_toggle_a: assert property (
		!$past(i_srst) |-> o_bus_clk_phase != $past(o_bus_clk_phase)) else $error("phase stuck");
	drive_len_a: assert property (
		$fell(o_rst_pin_oe) |-> oe_len_r == 13'h0020 || oe_len_r == 13'h1000) else $error("drive");
	internal_reset_tail_a: assert property (
		$fell(o_rst_pin_oe) |-> o_internal_reset [*8]) else $error("tail short");
	reset_gates_a: assert property (
		o_internal_reset |-> !o_cpu_clk_en && !o_module_clk_en) else $error("clock in reset");
	illegal_op_a: assert property (
		(i_bad_opcode || (i_stop_exec && !i_halt_allow)) && !o_internal_reset
		|-> ##[1:2] o_rst_pin_oe) else $error("no opcode reset");
	svc_clear_a: assert property (
		i_wr && i_addr == 16'hFFFF |=> o_wdog_clear
		##1 (!o_wdog_clear || $past(i_wr && i_addr == 16'hFFFF))) else $error("service");
	vec_sel_a: assert property (
		!$past(i_srst) |-> o_vector_addr == ($past(i_monitor_mode) ? 16'hFEFE : 16'hFFFE))
		else $error("vector");
	pin_halts_a: assert property (
		!i_rst_pin_in [*5] |-> o_internal_reset) else $error("pin ignored");
	cover property ($fell(o_rst_pin_oe));
	cover property (i_wr && i_addr == 16'hFFFF);
	cover property (!i_rst_pin_in && !o_rst_pin_oe);
endmodule
bind rsq_sequencer rsq_seq_chk #(.P_PIN_LONG_CYC(P_PIN_LONG_CYC)) chk_u (.*);

//--- rsq_ext_chip.sv
`timescale 1ns/1ps
module rsq_ext_chip (
	input wire logic i_clk,
	input wire logic i_dev_oe,
	input wire logic i_dev_out,
	output logic o_pin
);
	logic pull_r = 1'b0;
	// shared line with pull-up, any driver wins low
	assign o_pin = i_dev_oe ? (i_dev_out && !pull_r) : !pull_r;
	// hold the line low for a chosen time
	task automatic hold_low(input int len);
		pull_r <= 1'b1;
		repeat (len) @(posedge i_clk);
		pull_r <= 1'b0;
	endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic i_clk, i_srst, i_wr, i_rd, halt, swk, mon, oe, pin, pout, internal_reset, cpu, modc, core, wclr, tick;
	logic [15:0] i_addr, vec;
	logic [8:0] ev;
	logic [7:0] rdata;
	logic [2:0] obs;
	int err_count, total_checks, n;
	// ev: 0 undervolt 1 watchdog 2 bad opcode 3 stop 4 fetch 5 unmapped 6 wait 7 wake 8 power
	logic [8:0] msk [6] = '{9'h001, 9'h100, 9'h002, 9'h004, 9'h008, 9'h030};
	logic [7:0] flg [6] = '{8'h02, 8'h80, 8'h20, 8'h10, 8'h10, 8'h08};
	assign obs = {cpu, internal_reset, oe};
	// the device's own long drive counts as pin low time, so the threshold stays full size
	rsq_sequencer #(.P_PIN_LONG_CYC(4163)) dut_u (
		.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(8'hA5),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_rst_pin_in(pin),
		.o_rst_pin_out(pout), .o_rst_pin_oe(oe), .i_powerup_pulse(ev[8]),
		.i_undervolt(ev[0]), .i_watchdog_ovf(ev[1]), .i_bad_opcode(ev[2]),
		.i_opcode_fetch(ev[4]), .i_fetch_unmapped(ev[5]), .i_stop_exec(ev[3]),
		.i_wait_exec(ev[6]), .i_wake(ev[7]), .i_halt_allow(halt),
		.i_short_wake_select(swk), .i_monitor_mode(mon), .o_internal_reset(internal_reset),
		.o_vector_addr(vec), .o_cpu_clk_en(cpu), .o_module_clk_en(modc),
		.o_core_src_clk_en(core), .o_bus_clk_phase(), .o_wdog_tick(tick), .o_wdog_clear(wclr)
	);
	rsq_ext_chip ext_u (.i_clk(i_clk), .i_dev_oe(oe), .i_dev_out(pout), .o_pin(pin));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask
	// waits for a level and leaves the cycle count in n; a hang ends the run
	task automatic till(input int s, input logic lv);
		n = 0;
		while (obs[s] !== lv) begin
			cyc(1);
			n++;
			if (n > 9000) begin
				err_count++;
				report_and_stop();
			end
		end
	endtask
	task automatic wr(input logic [15:0] a);
		i_wr <= 1'b1;
		i_addr <= a;
		cyc(1);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		cyc(1);
		i_rd <= 1'b0;
		chk("rdata", {8'h00, rdata}, {8'h00, e});
	endtask
	task automatic fire(input logic [8:0] m);
		ev <= m;
		cyc(1);
		ev <= 9'h000;
	endtask
	task automatic pinl(input int len, input logic [7:0] f);
		ext_u.hold_low(len);
		till(1, 1'b0);
		rd(16'hFE01, f);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	initial begin
		{i_srst, i_wr, i_rd, halt, swk, mon} = 6'b100100;
		ev = 9'h000;
		i_addr = 16'h0000;
		repeat (16) @(posedge i_clk);
		i_srst <= 1'b0;
		cyc(1);
		chk("por", obs, 3'b011);
		rd(16'hFE01, 8'h80);
		till(0, 1'b0);
		chk("por_pin", n > 4090, 1'b1);
		till(1, 1'b0);
		chk("por_cpu", n inside {[63:65]}, 1'b1);
		pinl(80, 8'h00);
		pinl(4200, 8'h40);
		for (int k = 0; k < 6; k++) begin
			halt <= k != 4;
			fire(msk[k]);
			till(0, 1'b1);
			chk("react", n < 6, 1'b1);
			chk("pin_out", pout, 1'b0);
			till(0, 1'b0);
			chk("drive", n - (k < 2 ? 4096 : 32) inside {[-1:1]}, 1'b1);
			till(1, 1'b0);
			chk("tail", n - (k < 2 ? 64 : 32) inside {[-1:1]}, 1'b1);
			rd(16'hFE01, flg[k]);
			chk("run", obs, 3'b100);
		end
		pinl(50, 8'h00);
		pinl(80, 8'h40);
		for (int s = 0; s < 2; s++) begin
			// short wake suits a canned oscillator only
			swk <= s == 0;
			fire(9'h008);
			cyc(2);
			chk("stop", core, 1'b0);
			fire(9'h080);
			till(2, 1'b1);
			chk("wake", n - (s == 0 ? 32 : 4096) inside {[-2:3]}, 1'b1);
		end
		fire(9'h040);
		cyc(1);
		chk("wait", {cpu, modc, core}, 3'b011);
		fire(9'h080);
		cyc(2);
		chk("woke", cpu, 1'b1);
		wr(16'hFFFF);
		chk("svc", wclr, 1'b1);
		cyc(1);
		chk("svc_end", wclr, 1'b0);
		// next tick comes a full wrap after service, less the kept low bits
		n = 0;
		while (tick !== 1'b1) begin
			cyc(1);
			n++;
			if (n > 9000) begin
				err_count++;
				report_and_stop();
			end
		end
		chk("wdog_tick", n inside {[8176:8191]}, 1'b1);
		wr(16'hFE01);
		rd(16'hFE01, 8'h00);
		cyc(1);
		rd(16'h1234, 8'h00);
		fire(9'h020);
		cyc(4);
		chk("data_miss", obs, 3'b100);
		mon <= 1'b1;
		cyc(2);
		chk("mon_vec", vec, 16'hFEFE);
		report_and_stop();
	end
endmodule
